// ### mifl_core_model.sv
`timescale 1ns/1ns
module mifl_core_model (
  input  wire sys_clk_i,
  input  wire int_req_i,
  input  wire return_from_interrupt_sel_i,
  output reg  ack_o,
  output reg  return_from_interrupt_o,
  output reg  ret_o
);
  int d;
  initial begin
    ack_o = 0;
    return_from_interrupt_o = 0;
    ret_o = 0;
    forever begin
      @(posedge sys_clk_i);
      if (int_req_i === 1'b1) begin
        d = $urandom_range(3);
        repeat (d) @(posedge sys_clk_i);
        ack_o <= 1'b1;
        @(posedge sys_clk_i);
        ack_o <= 1'b0;
        // handler saves its own registers here, only pc was pushed
        repeat (3) @(posedge sys_clk_i);
        return_from_interrupt_o <= return_from_interrupt_sel_i;
        ret_o <= !return_from_interrupt_sel_i;
        @(posedge sys_clk_i);
        return_from_interrupt_o <= 1'b0;
        ret_o <= 1'b0;
      end
    end
  end
endmodule // mifl_core_model

// ### mifl_defines.vh
`ifndef MIFL_DEFINES_VH
`define MIFL_DEFINES_VH

// ==========================================================
// register offsets
`define MIFL_ADDR_CTRL    4'h0
`define MIFL_ADDR_FLAGS   4'h1
`define MIFL_ADDR_STATUS  4'h2
`define MIFL_ADDR_OVRUN   4'h3

// ==========================================================
// status register fields
`define MIFL_STAT_REQ     0
`define MIFL_STAT_VEC     1
`define MIFL_STAT_BUSY    3
`define MIFL_STAT_PEND    4

// ==========================================================
// control register fields
`define MIFL_CTRL_GIE     0
`define MIFL_CTRL_NVME    1
`define MIFL_CTRL_MFE     2
`define MIFL_CTRL_TPE     3
`define MIFL_CTRL_TAE     4
`define MIFL_CTRL_CVE     5
`define MIFL_CTRL_RST     8'h00

// ==========================================================
// flag register fields
`define MIFL_FLG_NVM      0
`define MIFL_FLG_MF       1
`define MIFL_FLG_TP       2
`define MIFL_FLG_TA       3
`define MIFL_FLG_CV       4

// ==========================================================
// vector codes, lowest first is highest priority
`define MIFL_VEC_NONE     2'h0
`define MIFL_VEC_NVM      2'h1
`define MIFL_VEC_MF       2'h2
`define MIFL_VEC_CV       2'h3

`endif

// ### mifl_top.v
`timescale 1ns/1ns
`include "mifl_defines.vh"

module mifl_top #(
  parameter ADDR_W  = 4,
  parameter DATA_W  = 8,
  parameter N_FLAGS = 5
) (
  input  wire              sys_clk_i,
  input  wire              reset_n_i,
  input  wire [ADDR_W-1:0] addr_i,
  input  wire [DATA_W-1:0] wdata_i,
  input  wire              wr_i,
  input  wire              rd_i,
  output reg  [DATA_W-1:0] rdata_o,
  input  wire              nvm_write_done_i,
  input  wire              timer_match_p_i,
  input  wire              timer_match_a_i,
  input  wire              conv_done_i,
  input  wire              stack_full_i,
  input  wire              low_power_i,
  input  wire              ack_i,
  input  wire              return_from_interrupt_i,
  input  wire              plain_return_i,
  output reg               int_req_o,
  output reg  [1:0]        int_vector_o,
  output reg               push_pc_o,
  output reg               wake_o
);

  // ========================================================
  // service phase codes
  localparam [1:0] ST_IDLE    = 2'b00;
  localparam [1:0] ST_CALL    = 2'b01;
  localparam [1:0] ST_HANDLER = 2'b10;

  // ========================================================
  // state
  reg  [DATA_W-1:0]  ctrl_reg;
  reg                nvm_write_done_flag_reg;
  reg                grouped_int_flags_reg;
  reg                timer_match_p_flag_reg;
  reg                timer_match_a_flag_reg;
  reg                conv_done_flag_reg;
  reg  [N_FLAGS-1:0] flags_prev_reg;
  reg  [3:0]         overrun_reg;
  reg  [1:0]         svc_state_reg;
  reg  [1:0]         svc_state_next;
  reg  [1:0]         vec_next;
  reg  [DATA_W-1:0]  status_word;

  wire global_int_enable    = ctrl_reg[`MIFL_CTRL_GIE];
  wire nvm_write_int_enable = ctrl_reg[`MIFL_CTRL_NVME];
  wire grouped_int_enable   = ctrl_reg[`MIFL_CTRL_MFE];
  wire timer_match_p_enable = ctrl_reg[`MIFL_CTRL_TPE];
  wire timer_match_a_enable = ctrl_reg[`MIFL_CTRL_TAE];
  wire conv_int_enable      = ctrl_reg[`MIFL_CTRL_CVE];

  wire [N_FLAGS-1:0] flags = {conv_done_flag_reg, timer_match_a_flag_reg, timer_match_p_flag_reg,
                              grouped_int_flags_reg, nvm_write_done_flag_reg};

  // ========================================================
  // address decode
  function addr_hit;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  wire wr_ctrl  = wr_i && addr_hit(addr_i, `MIFL_ADDR_CTRL);
  wire wr_flags = wr_i && addr_hit(addr_i, `MIFL_ADDR_FLAGS);
  wire wr_ovr   = wr_i && addr_hit(addr_i, `MIFL_ADDR_OVRUN);

  // ========================================================
  // priority pick, lowest vector first
  function [1:0] pick_vector;
    input [2:0] mask;
    begin
      if (mask[0])
        pick_vector = `MIFL_VEC_NVM;
      else if (mask[1])
        pick_vector = `MIFL_VEC_MF;
      else if (mask[2])
        pick_vector = `MIFL_VEC_CV;
      else
        pick_vector = `MIFL_VEC_NONE;
    end
  endfunction

  // ========================================================
  // arbitration
  // a timer match raises the grouped flag only if its own enable is set
  wire grp_src = (timer_match_p_i && timer_match_p_enable) ||
                 (timer_match_a_i && timer_match_a_enable);
  // one call at a time: nothing new until the core has taken the last one
  wire can_take = global_int_enable && !stack_full_i && !int_req_o;

  wire [2:0] pend_mask;
  assign pend_mask[0] = nvm_write_int_enable && nvm_write_done_flag_reg;
  assign pend_mask[1] = grouped_int_enable && grouped_int_flags_reg;
  assign pend_mask[2] = conv_int_enable && conv_done_flag_reg;

  always @* begin
    if (can_take)
      vec_next = pick_vector(pend_mask);
    else
      vec_next = `MIFL_VEC_NONE;
  end

  wire service = (vec_next != `MIFL_VEC_NONE);

  // ========================================================
  // control register and global enable
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= `MIFL_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata_i;
      end
      // a service in the cycle of a software write still wins the enable
      if (service) begin
        ctrl_reg[`MIFL_CTRL_GIE] <= 1'b0;
      end else if (return_from_interrupt_i) begin
        ctrl_reg[`MIFL_CTRL_GIE] <= 1'b1;
      end
    end
  end

  // ========================================================
  // request flags; a hardware set beats the service clear and software
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      nvm_write_done_flag_reg <= 1'b0;
    end else if (nvm_write_done_i) begin
      nvm_write_done_flag_reg <= 1'b1;
    end else if (vec_next == `MIFL_VEC_NVM) begin
      nvm_write_done_flag_reg <= 1'b0;
    end else if (wr_flags) begin
      nvm_write_done_flag_reg <= wdata_i[`MIFL_FLG_NVM];
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      grouped_int_flags_reg <= 1'b0;
    end else if (grp_src) begin
      grouped_int_flags_reg <= 1'b1;
    end else if (vec_next == `MIFL_VEC_MF) begin
      grouped_int_flags_reg <= 1'b0;
    end else if (wr_flags) begin
      grouped_int_flags_reg <= wdata_i[`MIFL_FLG_MF];
    end
  end

  // timer flags are never cleared by service, only by software
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      timer_match_p_flag_reg <= 1'b0;
    end else if (timer_match_p_i) begin
      timer_match_p_flag_reg <= 1'b1;
    end else if (wr_flags) begin
      timer_match_p_flag_reg <= wdata_i[`MIFL_FLG_TP];
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      timer_match_a_flag_reg <= 1'b0;
    end else if (timer_match_a_i) begin
      timer_match_a_flag_reg <= 1'b1;
    end else if (wr_flags) begin
      timer_match_a_flag_reg <= wdata_i[`MIFL_FLG_TA];
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      conv_done_flag_reg <= 1'b0;
    end else if (conv_done_i) begin
      conv_done_flag_reg <= 1'b1;
    end else if (vec_next == `MIFL_VEC_CV) begin
      conv_done_flag_reg <= 1'b0;
    end else if (wr_flags) begin
      conv_done_flag_reg <= wdata_i[`MIFL_FLG_CV];
    end
  end

  // ========================================================
  // overrun: an event that finds its flag already set is otherwise lost;
  // software reads these sticky bits and writes ones to clear them
  wire [3:0] ev_in   = {conv_done_i, timer_match_a_i, timer_match_p_i, nvm_write_done_i};
  wire [3:0] ev_flag = {conv_done_flag_reg, timer_match_a_flag_reg, timer_match_p_flag_reg,
                        nvm_write_done_flag_reg};

  genvar gi;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ovr
      always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
          overrun_reg[gi] <= 1'b0;
        end else if (ev_in[gi] && ev_flag[gi]) begin
          overrun_reg[gi] <= 1'b1;
        end else if (wr_ovr && wdata_i[gi]) begin
          overrun_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ========================================================
  // call request toward the core, held until the core acknowledges
  always @(posedge sys_clk_i) begin
    if (!reset_n_i)
      int_req_o <= 1'b0;
    else if (service)
      int_req_o <= 1'b1;
    else if (ack_i)
      int_req_o <= 1'b0;
  end

  // the vector stays readable after the call is taken
  always @(posedge sys_clk_i) begin
    if (!reset_n_i)
      int_vector_o <= `MIFL_VEC_NONE;
    else if (service)
      int_vector_o <= vec_next;
  end

  // only the program counter is pushed; the handler saves everything else
  always @(posedge sys_clk_i) begin
    if (!reset_n_i)
      push_pc_o <= 1'b0;
    else
      push_pc_o <= service;
  end

  // ========================================================
  // service phase, for software that polls the status register
  always @* begin
    svc_state_next = svc_state_reg;
    case (svc_state_reg)
      ST_IDLE: begin
        if (service) begin
          svc_state_next = ST_CALL;
        end
      end
      ST_CALL: begin
        if (ack_i) begin
          svc_state_next = ST_HANDLER;
        end
      end
      ST_HANDLER: begin
        // either return ends the handler; only the interrupt return re-enables
        if (return_from_interrupt_i) begin
          svc_state_next = ST_IDLE;
        end else if (plain_return_i) begin
          svc_state_next = ST_IDLE;
        end
      end
      default: begin
        svc_state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      svc_state_reg <= ST_IDLE;
    end else begin
      svc_state_reg <= svc_state_next;
    end
  end

  // ========================================================
  // wake-up; enables are ignored and a preset flag never rises
  wire [N_FLAGS-1:0] flag_rise;

  generate
    for (gi = 0; gi < N_FLAGS; gi = gi + 1) begin : g_rise
      assign flag_rise[gi] = flags[gi] && !flags_prev_reg[gi];
    end
  endgenerate

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      flags_prev_reg <= {N_FLAGS{1'b0}};
      wake_o         <= 1'b0;
    end else begin
      flags_prev_reg <= flags;
      wake_o         <= low_power_i && (flag_rise != {N_FLAGS{1'b0}});
    end
  end

  // ========================================================
  // status word: request, vector, handler phase, sources ready to go
  always @* begin
    status_word                                      = {DATA_W{1'b0}};
    status_word[`MIFL_STAT_REQ]                      = int_req_o;
    status_word[`MIFL_STAT_VEC+1:`MIFL_STAT_VEC]     = int_vector_o;
    status_word[`MIFL_STAT_BUSY]                     = (svc_state_reg == ST_HANDLER);
    status_word[`MIFL_STAT_PEND+2:`MIFL_STAT_PEND]   = pend_mask;
  end

  // ========================================================
  // register read; data stands for one cycle only
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= {DATA_W{1'b0}};
    end else if (rd_i) begin
      case (addr_i)
        `MIFL_ADDR_CTRL:   rdata_o <= ctrl_reg;
        `MIFL_ADDR_FLAGS:  rdata_o <= {{(DATA_W-N_FLAGS){1'b0}}, flags};
        `MIFL_ADDR_STATUS: rdata_o <= status_word;
        `MIFL_ADDR_OVRUN:  rdata_o <= {{(DATA_W-4){1'b0}}, overrun_reg};
        default:           rdata_o <= {DATA_W{1'b0}};
      endcase
    end else begin
      rdata_o <= {DATA_W{1'b0}};
    end
  end

endmodule // mifl_top

// ### mifl_top_asserts.sv
`timescale 1ns/1ns
module mifl_top_asserts (
  input wire       sys_clk_i,
  input wire       reset_n_i,
  input wire       stack_full_i,
  input wire       low_power_i,
  input wire       ack_i,
  input wire       int_req_o,
  input wire [1:0] int_vector_o,
  input wire       push_pc_o,
  input wire       wake_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req;
    !int_req_o ##1 int_req_o;
  endsequence
  AST_PUSH: assert property (s_req |-> push_pc_o) else $error("push missing");
  AST_PUSH_ONE: assert property (push_pc_o |=> !push_pc_o) else $error("push long");
  AST_STACK: assert property (s_req |-> !$past(stack_full_i)) else $error("stack full");
  AST_HOLD: assert property (int_req_o && !ack_i |=> int_req_o) else $error("req dropped");
  AST_ACK: assert property (int_req_o && ack_i |=> !int_req_o) else $error("req kept");
  AST_VEC: assert property (int_req_o |-> int_vector_o != 2'h0) else $error("no vector");
  AST_VSTB: assert property (int_req_o && !ack_i |=> $stable(int_vector_o)) else $error("vec moved");
  AST_WAKE: assert property (wake_o |-> $past(low_power_i)) else $error("wake awake");
endmodule // mifl_top_asserts
bind mifl_top mifl_top_asserts u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .stack_full_i(stack_full_i), .low_power_i(low_power_i), .ack_i(ack_i), .int_req_o(int_req_o),
  .int_vector_o(int_vector_o), .push_pc_o(push_pc_o), .wake_o(wake_o));

// ### mifl_top_bench.sv
`timescale 1ns/1ns
module mifl_top_bench;
  reg         sys_clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, sf = 0, lp = 0, rsel = 1;
  reg   [3:0] addr_i = 0, evs = 0;
  reg   [7:0] wdata_i = 0;
  wire  [7:0] rdata_o;
  wire  [1:0] vec;
  wire        req, push, wake, ack, return_from_interrupt, ret;
  int         miscompares = 0, n_compared = 0, v;
  logic [7:0] n_wake = 0, exp_q[$];
  logic       prev = 0;
  mifl_top uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nvm_write_done_i(evs[0]), .timer_match_p_i(evs[1]),
    .timer_match_a_i(evs[2]), .conv_done_i(evs[3]), .stack_full_i(sf), .low_power_i(lp), .ack_i(ack),
    .return_from_interrupt_i(return_from_interrupt), .plain_return_i(ret), .int_req_o(req), .int_vector_o(vec),
    .push_pc_o(push), .wake_o(wake));
  mifl_core_model core (.sys_clk_i(sys_clk_i), .int_req_i(req), .return_from_interrupt_sel_i(rsel), .ack_o(ack),
    .return_from_interrupt_o(return_from_interrupt), .ret_o(ret));
  // ==========================================================
  // bus, event, compare and report tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, e, rdata_o & m);
  endtask
  task automatic ev(input logic [3:0] s);
    @(posedge sys_clk_i);
    evs <= s;
    @(posedge sys_clk_i);
    evs <= 4'h0;
    repeat (40) @(posedge sys_clk_i);
  endtask
  task automatic complete_run;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // reference: every new call must match the next queued vector
  always @(posedge sys_clk_i) begin
    prev <= req;
    if (wake === 1'b1) n_wake <= n_wake + 8'h01;
    if (req === 1'b1 && prev === 1'b0) chk("vector", exp_q.pop_front(), {6'h00, vec});
  end
  initial forever #5 sys_clk_i = ~sys_clk_i;
  initial begin
    #100000 miscompares++;
    complete_run();
  end
  // ==========================================================
  // scenarios
  initial begin
    v = $urandom(32'h9500);
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd(4'h0, 8'hff, 8'h00, "ctrl");
    rd(4'h7, 8'hff, 8'h00, "unmapped");
    repeat (4) begin
      v = $urandom_range(31);
      wr(4'h1, v[7:0]);
      rd(4'h1, 8'h1f, v[7:0], "flags");
    end
    wr(4'h1, 8'h00);
    sf <= 1'b1;
    wr(4'h0, 8'h3f);
    ev(4'h9);
    rd(4'h1, 8'h1f, 8'h11, "flags");
    exp_q = '{8'h01, 8'h03};
    @(posedge sys_clk_i);
    sf <= 1'b0;
    repeat (40) @(posedge sys_clk_i);
    rd(4'h1, 8'h1f, 8'h00, "flags");
    rd(4'h0, 8'h01, 8'h01, "global");
    @(posedge sys_clk_i);
    rsel <= 1'b0;
    exp_q.push_back(8'h02);
    ev(4'h6);
    rd(4'h1, 8'h1f, 8'h0c, "flags");
    rd(4'h0, 8'h01, 8'h00, "global");
    rd(4'h2, 8'hff, 8'h04, "status");
    wr(4'h1, 8'h10);
    @(posedge sys_clk_i);
    lp <= 1'b1;
    ev(4'h8);
    chk("wake", 8'h00, n_wake);
    wr(4'h1, 8'h00);
    ev(4'h8);
    chk("wake", 8'h01, n_wake);
    rd(4'h3, 8'hff, 8'h08, "overrun");
    complete_run();
  end
endmodule // mifl_top_bench
